// ### hdl/dtc_defs.svh
/*
  Constants of the dual timer/counter block: register addresses in the
  special function space, control and mode field positions, reset values and
  the clock and count figures. Assumes inclusion by bare name only.
*/
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define DTC_ADDR_CTRL 8'h88
`define DTC_ADDR_A_LOW 8'h8a
`define DTC_ADDR_B_LOW 8'h8b
`define DTC_ADDR_A_HIGH 8'h8c
`define DTC_ADDR_B_HIGH 8'h8d
`define DTC_CTRL_BIT_BASE 5'h11

// ----------------------------------------------------------------
// Control register bits
// ----------------------------------------------------------------
`define DTC_B_OVF_BIT 7
`define DTC_B_RUN_BIT 6
`define DTC_A_OVF_BIT 5
`define DTC_A_RUN_BIT 4
`define DTC_EXT_B_FLAG_BIT 3
`define DTC_EXT_B_EDGE_BIT 2
`define DTC_EXT_A_FLAG_BIT 1
`define DTC_EXT_A_EDGE_BIT 0
`define DTC_CTRL_RESET 8'h00

// ----------------------------------------------------------------
// Mode register fields, per timer nibble
// ----------------------------------------------------------------
`define DTC_MODE_NIBBLE_W 4
`define DTC_MODE_GATE_OFS 3
`define DTC_MODE_SEL_OFS 2

// ----------------------------------------------------------------
// Clock and count figures
// ----------------------------------------------------------------
`define DTC_CLK_HZ 20000000
`define DTC_MC_CLOCKS 12
`define DTC_PRESC_W 5

`endif

// ### hdl/dtc_pkg.sv
/*
  Types of the dual timer/counter block: the mode code and the packed state.
  Assumes the constants header sits in the include path.
*/
`include "dtc_defs.svh"

package dtc_pkg;

  // ----------------------------------------------------------------
  // Mode codes of the two-bit mode field
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DTC_MODE_PRESC13 = 2'b00,
    DTC_MODE_FULL16 = 2'b01,
    DTC_MODE_RELOAD8 = 2'b10,
    DTC_MODE_HOLD = 2'b11
  } dtc_mode_e;

  // ----------------------------------------------------------------
  // Whole state of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic [1:0][7:0] cnt_low;
    logic [1:0][7:0] cnt_high;
    logic [1:0] ext_s1;
    logic [1:0] ext_s2;
    logic [1:0] ext_d;
    logic [1:0] cnt_s1;
    logic [1:0] cnt_s2;
    logic [1:0] cnt_d;
    logic [3:0] mc_cnt;
    logic [7:0] rdata;
    logic rd_hit;
  } dtc_state_s;

endpackage

// ### hdl/dtc_top.sv
/*
  Dual timer/counter with the shared control register that also holds the
  two external interrupt flags and their trigger-type bits.
  Assumes a core on the same clock that reads and writes the special
  function space, supplies the mode register byte, and pulses a vector
  strobe when it enters a service routine. Pins are asynchronous.
*/
`timescale 1ns/1ps
`include "dtc_defs.svh"

module dtc_top (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_bit_wr,
  input wire logic [7:0] i_bit_addr,
  input wire logic i_bit_wdata,
  input wire logic [7:0] i_timer_mode,
  input wire logic i_vec_timer_a,
  input wire logic i_vec_timer_b,
  input wire logic i_vec_ext_a,
  input wire logic i_vec_ext_b,
  input wire logic i_ext_irq_a_pin,
  input wire logic i_ext_irq_b_pin,
  input wire logic i_timer_a_count_pin,
  input wire logic i_timer_b_count_pin,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_rd_hit,
  output logic o_timer_a_irq,
  output logic o_timer_b_irq,
  output logic o_ext_irq_a,
  output logic o_ext_irq_b
);
  import dtc_pkg::*;

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam logic [3:0] MC_LAST = 4'(`DTC_MC_CLOCKS - 1);
  localparam logic [4:0] PRESC_ALL = 5'h1f;

  dtc_state_s s_r;
  dtc_state_s s_nxt;

  // ----------------------------------------------------------------
  // Machine cycle enable and pin edges
  // ----------------------------------------------------------------
  logic mc_tick;
  logic [1:0] cnt_fall;
  logic [1:0] ext_fall;

  // One enable pulse per twelve clocks drives timer function
  assign mc_tick = (s_r.mc_cnt == MC_LAST);

  // Edges are taken from the second sync stage and its delayed copy only
  assign cnt_fall = s_r.cnt_d & ~s_r.cnt_s2;
  assign ext_fall = s_r.ext_d & ~s_r.ext_s2;

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  logic ctrl_byte_wr;
  logic ctrl_bit_wr;
  logic [2:0] ctrl_bit_sel;
  logic [1:0] low_wr;
  logic [1:0] high_wr;

  assign ctrl_byte_wr = i_sfr_wr && (i_sfr_addr == `DTC_ADDR_CTRL);
  assign ctrl_bit_wr = i_bit_wr && (i_bit_addr[7:3] == `DTC_CTRL_BIT_BASE);
  assign ctrl_bit_sel = i_bit_addr[2:0];
  assign low_wr[0] = i_sfr_wr && (i_sfr_addr == `DTC_ADDR_A_LOW);
  assign high_wr[0] = i_sfr_wr && (i_sfr_addr == `DTC_ADDR_A_HIGH);
  assign low_wr[1] = i_sfr_wr && (i_sfr_addr == `DTC_ADDR_B_LOW);
  assign high_wr[1] = i_sfr_wr && (i_sfr_addr == `DTC_ADDR_B_HIGH);

  // ----------------------------------------------------------------
  // Per timer count path
  // ----------------------------------------------------------------
  logic [1:0][7:0] inc_low;
  logic [1:0][7:0] inc_high;
  logic [1:0] ovf;

  // Same path for both timers; only the run bit and mode nibble positions differ
  genvar t;
  generate
    for (t = 0; t < 2; t++) begin : g_timer
      localparam int RUN_BIT = (t == 0) ? `DTC_A_RUN_BIT : `DTC_B_RUN_BIT;
      localparam int NIB = t * `DTC_MODE_NIBBLE_W;
      logic gate;
      logic sel_pin;
      dtc_mode_e mode;
      logic tick;
      logic en;
      logic presc_carry;
      logic [15:0] wide;

      assign gate = i_timer_mode[NIB + `DTC_MODE_GATE_OFS];
      assign sel_pin = i_timer_mode[NIB + `DTC_MODE_SEL_OFS];
      assign mode = dtc_mode_e'(i_timer_mode[NIB +: 2]);
      assign tick = sel_pin ? cnt_fall[t] : mc_tick;
      // Gate pin is read after its synchroniser, so pulse edges lag two clocks
      assign en = s_r.ctrl[RUN_BIT] && (!gate || s_r.ext_s2[t]) && tick;
      assign presc_carry = (s_r.cnt_low[t][4:0] == PRESC_ALL);
      assign wide = {s_r.cnt_high[t], s_r.cnt_low[t]} + 16'h0001;

      always_comb begin
        inc_low[t] = s_r.cnt_low[t];
        inc_high[t] = s_r.cnt_high[t];
        ovf[t] = 1'b0;
        if (en) begin
          unique case (mode)
            DTC_MODE_PRESC13: begin
              // Upper three low bits are left alone and carry no meaning
              inc_low[t] = {s_r.cnt_low[t][7:5], s_r.cnt_low[t][4:0] + 5'h01};
              if (presc_carry) begin
                inc_high[t] = s_r.cnt_high[t] + 8'h01;
              end
              ovf[t] = presc_carry && (s_r.cnt_high[t] == 8'hff);
            end
            DTC_MODE_FULL16: begin
              inc_low[t] = wide[7:0];
              inc_high[t] = wide[15:8];
              ovf[t] = ({s_r.cnt_high[t], s_r.cnt_low[t]} == 16'hffff);
            end
            // Reload and split modes belong elsewhere; the count holds here
            DTC_MODE_RELOAD8: begin
              ovf[t] = 1'b0;
            end
            DTC_MODE_HOLD: begin
              ovf[t] = 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [7:0] ctrl_sw;
  logic [1:0] ext_edge_mode;
  logic [1:0] ext_vec;

  assign ext_edge_mode = {s_r.ctrl[`DTC_EXT_B_EDGE_BIT], s_r.ctrl[`DTC_EXT_A_EDGE_BIT]};
  assign ext_vec = {i_vec_ext_b, i_vec_ext_a};

  always_comb begin
    s_nxt = s_r;

    // Two-stage synchronisers, then one delay stage for edge detection
    s_nxt.ext_s1 = {i_ext_irq_b_pin, i_ext_irq_a_pin};
    s_nxt.ext_s2 = s_r.ext_s1;
    s_nxt.ext_d = s_r.ext_s2;
    s_nxt.cnt_s1 = {i_timer_b_count_pin, i_timer_a_count_pin};
    s_nxt.cnt_s2 = s_r.cnt_s1;
    s_nxt.cnt_d = s_r.cnt_s2;

    s_nxt.mc_cnt = mc_tick ? 4'h0 : s_r.mc_cnt + 4'h1;

    // Count bytes; a software write beats a coincident increment
    for (int i = 0; i < 2; i++) begin
      s_nxt.cnt_low[i] = low_wr[i] ? i_sfr_wdata : inc_low[i];
      s_nxt.cnt_high[i] = high_wr[i] ? i_sfr_wdata : inc_high[i];
    end

    // Control: vector clears first, then software, then hardware sets
    ctrl_sw = s_r.ctrl;
    if (i_vec_timer_b) begin
      ctrl_sw[`DTC_B_OVF_BIT] = 1'b0;
    end
    if (i_vec_timer_a) begin
      ctrl_sw[`DTC_A_OVF_BIT] = 1'b0;
    end
    if (ext_vec[1] && ext_edge_mode[1]) begin
      ctrl_sw[`DTC_EXT_B_FLAG_BIT] = 1'b0;
    end
    if (ext_vec[0] && ext_edge_mode[0]) begin
      ctrl_sw[`DTC_EXT_A_FLAG_BIT] = 1'b0;
    end
    if (ctrl_byte_wr) begin
      ctrl_sw = i_sfr_wdata;
    end else if (ctrl_bit_wr) begin
      ctrl_sw[ctrl_bit_sel] = i_bit_wdata;
    end

    // Run bits only gate counting; the count bytes are never cleared here
    s_nxt.ctrl = ctrl_sw;

    // Set wins over any clear in the same cycle
    if (ovf[1]) begin
      s_nxt.ctrl[`DTC_B_OVF_BIT] = 1'b1;
    end
    if (ovf[0]) begin
      s_nxt.ctrl[`DTC_A_OVF_BIT] = 1'b1;
    end

    // Level mode: the pin owns the flag, software writes are overridden
    if (ext_edge_mode[1]) begin
      if (ext_fall[1]) begin
        s_nxt.ctrl[`DTC_EXT_B_FLAG_BIT] = 1'b1;
      end
    end else begin
      s_nxt.ctrl[`DTC_EXT_B_FLAG_BIT] = ~s_r.ext_s2[1];
    end
    if (ext_edge_mode[0]) begin
      if (ext_fall[0]) begin
        s_nxt.ctrl[`DTC_EXT_A_FLAG_BIT] = 1'b1;
      end
    end else begin
      s_nxt.ctrl[`DTC_EXT_A_FLAG_BIT] = ~s_r.ext_s2[0];
    end

    // Read data, registered one cycle; unmapped addresses read zero
    s_nxt.rdata = 8'h00;
    s_nxt.rd_hit = 1'b0;
    if (i_sfr_rd) begin
      s_nxt.rd_hit = 1'b1;
      unique case (i_sfr_addr)
        `DTC_ADDR_CTRL: begin
          s_nxt.rdata = s_r.ctrl;
        end
        `DTC_ADDR_A_LOW: begin
          s_nxt.rdata = s_r.cnt_low[0];
        end
        `DTC_ADDR_A_HIGH: begin
          s_nxt.rdata = s_r.cnt_high[0];
        end
        `DTC_ADDR_B_LOW: begin
          s_nxt.rdata = s_r.cnt_low[1];
        end
        `DTC_ADDR_B_HIGH: begin
          s_nxt.rdata = s_r.cnt_high[1];
        end
        default: begin
          s_nxt.rd_hit = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Pin sync stages reset high so no false falling edge follows reset
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      s_r <= '0;
      s_r.ctrl <= `DTC_CTRL_RESET;
      s_r.ext_s1 <= 2'h3;
      s_r.ext_s2 <= 2'h3;
      s_r.ext_d <= 2'h3;
      s_r.cnt_s1 <= 2'h3;
      s_r.cnt_s2 <= 2'h3;
      s_r.cnt_d <= 2'h3;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, straight from state flops
  // ----------------------------------------------------------------
  assign o_sfr_rdata = s_r.rdata;
  assign o_sfr_rd_hit = s_r.rd_hit;
  assign o_timer_a_irq = s_r.ctrl[`DTC_A_OVF_BIT];
  assign o_timer_b_irq = s_r.ctrl[`DTC_B_OVF_BIT];
  assign o_ext_irq_a = s_r.ctrl[`DTC_EXT_A_FLAG_BIT];
  assign o_ext_irq_b = s_r.ctrl[`DTC_EXT_B_FLAG_BIT];

endmodule

// ### test/dtc_sva.sv
/* Checker on the top ports of the dual timer block.
   Assumes a bind to dtc_top and pins that hold each level two clocks. */
`timescale 1ns/1ps
module dtc_sva (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_bit_wr,
  input wire logic [7:0] i_bit_addr,
  input wire logic i_bit_wdata,
  input wire logic [7:0] i_timer_mode,
  input wire logic i_ext_irq_a_pin,
  input wire logic i_ext_irq_b_pin,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_sfr_rd_hit,
  input wire logic o_timer_a_irq,
  input wire logic o_timer_b_irq,
  input wire logic o_ext_irq_a,
  input wire logic o_ext_irq_b
);
  // ------
  // Shadow of software bits, exact since only software writes them
  // ------
  logic [7:0] sw_r;
  logic [7:0] sw_nxt;
  logic [2:0] age_r;
  logic bit_hit;
  logic ctl_wr;
  logic mapped;
  always_comb begin
    bit_hit = i_bit_wr && i_bit_addr[7:3] == 5'h11;
    ctl_wr = (i_sfr_wr && i_sfr_addr == 8'h88) || bit_hit;
    mapped = i_sfr_addr == 8'h88 || (i_sfr_addr >= 8'h8a && i_sfr_addr <= 8'h8d);
    sw_nxt = sw_r;
    if (i_sfr_wr && i_sfr_addr == 8'h88) begin
      sw_nxt = i_sfr_wdata;
    end else if (bit_hit) begin
      sw_nxt[i_bit_addr[2:0]] = i_bit_wdata;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sw_r <= 8'h00;
      age_r <= 3'h0;
    end else begin
      sw_r <= sw_nxt;
      age_r <= (age_r == 3'h7) ? age_r : age_r + 3'h1;
    end
  end
  // ------
  // Properties
  // ------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  sequence s_fall_b;
    age_r == 3'h7 && sw_r[2] && $fell(i_ext_irq_b_pin) ##1 sw_r[2] [*2];
  endsequence
  a_read_mapped_hit: assert property (i_sfr_rd && mapped |=> o_sfr_rd_hit)
    else $error("read of a mapped register gave no hit");
  a_read_unmapped_zero: assert property (i_sfr_rd && !mapped |=> !o_sfr_rd_hit && o_sfr_rdata == 8'h00)
    else $error("unmapped read answered");
  a_hit_from_read: assert property (o_sfr_rd_hit |-> $past(i_sfr_rd) && $past(mapped))
    else $error("read hit without a read");
  a_rdata_idle_zero: assert property (!o_sfr_rd_hit |-> o_sfr_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_level_a_follows: assert property (age_r == 3'h7 && !sw_r[0] && !$past(sw_r[0])
    |-> o_ext_irq_a == !$past(i_ext_irq_a_pin, 3))
    else $error("level flag a does not follow the pin");
  a_edge_b_sets: assert property (s_fall_b |=> o_ext_irq_b)
    else $error("falling edge on pin b not flagged");
  a_run_a_needed: assert property ($rose(o_timer_a_irq) && !$past(ctl_wr)
    |-> $past(sw_r[4]) && !$past(i_timer_mode[1]))
    else $error("timer a overflowed while stopped");
  a_run_b_needed: assert property ($rose(o_timer_b_irq) && !$past(ctl_wr)
    |-> $past(sw_r[6]) && !$past(i_timer_mode[5]))
    else $error("timer b overflowed while stopped");
endmodule
bind dtc_top dtc_sva u_sva (.i_ref_clk, .i_rst, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata, .i_bit_wr,
  .i_bit_addr, .i_bit_wdata, .i_timer_mode, .i_ext_irq_a_pin, .i_ext_irq_b_pin, .o_sfr_rdata, .o_sfr_rd_hit,
  .o_timer_a_irq, .o_timer_b_irq, .o_ext_irq_a, .o_ext_irq_b);

// ### test/dtc_pins.sv
/* Model of the external interrupt, gate and count pins.
   Assumes the bench asks for pin levels on the core clock. */
`timescale 1ns/1ps
module dtc_pins (
  input wire logic i_ref_clk,
  input wire logic [1:0] i_ext_lvl,
  input wire logic [1:0] i_cnt_run,
  output logic [1:0] o_ext_pin,
  output logic [1:0] o_cnt_pin
);
  // ------
  // Pin drivers
  // ------
  logic [1:0][1:0] hold;
  logic [1:0][1:0] ph;
  initial begin
    o_ext_pin = 2'h3;
    hold = '0;
    ph = '0;
  end
  // Count pins stand high while idle; each level lasts two clocks
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      o_cnt_pin[i] = !ph[i][1];
    end
  end
  always @(posedge i_ref_clk) begin
    for (int i = 0; i < 2; i++) begin
      // A low pin both requests and closes the gate; never shorter than the sampling needs
      if (hold[i] != 2'h2) begin
        hold[i] <= hold[i] + 2'h1;
      end else if (i_ext_lvl[i] != o_ext_pin[i]) begin
        o_ext_pin[i] <= i_ext_lvl[i];
        hold[i] <= 2'h0;
      end
      if (i_cnt_run[i] || ph[i] != 2'h0) begin
        ph[i] <= ph[i] + 2'h1;
      end
    end
  end
endmodule

// ### test/dual_timer_counter_ext_irq_flags_test.sv
/* Self-checking bench of the dual timer block with the pin model.
   Assumes dtc_top, dtc_pins and the bound checker are compiled first. */
`timescale 1ns/1ps
module dual_timer_counter_ext_irq_flags_test;
  import dtc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, baddr = 8'h00, tmode = 8'h22, rdata;
  logic wr = 1'b0, rd = 1'b0, bwr = 1'b0, bdat = 1'b0, hit, e;
  logic [1:0] vt = 2'h0, ve = 2'h0, lvl = 2'h3, crun = 2'h0, ep, cp, ti, ei;
  logic [3:0][7:0] v;
  logic [7:0] i;
  logic [31:0] seed = 32'h0000000c;
  int n_mismatch = 0, checks = 0, cyc = 0;
  wire [3:0] irq = {ei, ti};
  always #25 clk = ~clk;
  dtc_top dut (.i_ref_clk(clk), .i_rst(rst), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd),
    .i_sfr_wdata(wdata), .i_bit_wr(bwr), .i_bit_addr(baddr), .i_bit_wdata(bdat), .i_timer_mode(tmode),
    .i_vec_timer_a(vt[0]), .i_vec_timer_b(vt[1]), .i_vec_ext_a(ve[0]), .i_vec_ext_b(ve[1]),
    .i_ext_irq_a_pin(ep[0]), .i_ext_irq_b_pin(ep[1]), .i_timer_a_count_pin(cp[0]),
    .i_timer_b_count_pin(cp[1]), .o_sfr_rdata(rdata), .o_sfr_rd_hit(hit), .o_timer_a_irq(ti[0]),
    .o_timer_b_irq(ti[1]), .o_ext_irq_a(ei[0]), .o_ext_irq_b(ei[1]));
  dtc_pins pins (.i_ref_clk(clk), .i_ext_lvl(lvl), .i_cnt_run(crun), .o_ext_pin(ep), .o_cnt_pin(cp));
  // ------
  // Helpers
  // ------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Low byte after a wrap: the prescaled mode leaves the top three bits alone
  function automatic logic [7:0] wrap_low(input logic [1:0] m, input logic [7:0] lo);
    return (m == 2'h0) ? {lo[7:5], 5'h00} : 8'h00;
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrb(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic bitw(input logic [7:0] a, input logic d);
    @(posedge clk);
    baddr <= a;
    bdat <= d;
    bwr <= 1'b1;
    @(posedge clk);
    bwr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] x, input logic h);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", rdata, x);
    chk("rd_hit", {7'h00, hit}, {7'h00, h});
  endtask
  task automatic pulse(input logic [7:0] k);
    @(posedge clk);
    if (k < 8'h02) begin
      vt[k] <= 1'b1;
    end else begin
      ve[k - 8'h02] <= 1'b1;
    end
    @(posedge clk);
    vt <= 2'h0;
    ve <= 2'h0;
  endtask
  // Waits up to n cycles for the request, then compares it
  task automatic waiti(input logic [7:0] k, input int n, input logic x);
    for (int j = 0; j < n && irq[k] !== 1'b1; j++) begin
      @(posedge clk);
      #1;
    end
    #1;
    chk("irq", {7'h00, irq[k]}, {7'h00, x});
  endtask
  task automatic tmr(input logic [7:0] t, input logic [7:0] m, input logic [7:0] hi, input logic [7:0] lo);
    wrb(8'h8c + t, hi);
    wrb(8'h8a + t, lo);
    tmode <= m << (8'h04 * t);
    bitw(8'h8c + 8'h02 * t, 1'b1);
  endtask
  task automatic fin(input logic [7:0] t, input logic [7:0] hi, input logic [7:0] lo);
    bitw(8'h8c + 8'h02 * t, 1'b0);
    rdc(8'h8c + t, hi, 1'b1);
    rdc(8'h8a + t, lo, 1'b1);
    rdc(8'h88, 8'h20 << (8'h02 * t), 1'b1);
    pulse(t);
    waiti(t, 0, 1'b0);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      results();
    end
  end
  // ------
  // Main sequence
  // ------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdc(8'h88, 8'h00, 1'b1);
    rdc(8'h89, 8'h00, 1'b0);
    rdc(8'h8e, 8'h00, 1'b0);
    repeat (3) begin
      for (int k = 0; k < 4; k++) begin
        seed = xs(seed);
        v[k] = seed[7:0];
        wrb(8'h8a + 8'(k), v[k]);
      end
      for (int k = 0; k < 4; k++) begin
        rdc(8'h8a + 8'(k), v[k], 1'b1);
      end
    end
    bitw(8'h8c, 1'b1);
    rdc(8'h88, 8'h10, 1'b1);
    bitw(8'h8c, 1'b0);
    $display("test registers done");
    tmr(8'h00, 8'h01, 8'hff, 8'hff);
    waiti(8'h00, 30, 1'b1);
    fin(8'h00, 8'h00, wrap_low(2'h1, 8'hff));
    tmr(8'h01, 8'h00, 8'hff, 8'hff);
    waiti(8'h01, 30, 1'b1);
    fin(8'h01, 8'h00, wrap_low(2'h0, 8'hff));
    tmr(8'h00, 8'h00, 8'hfe, 8'h1f);
    waiti(8'h00, 300, 1'b0);
    waiti(8'h00, 150, 1'b1);
    fin(8'h00, 8'h00, 8'h00);
    $display("test overflow done");
    lvl[0] <= 1'b0;
    tmr(8'h00, 8'h09, 8'hff, 8'hff);
    waiti(8'h00, 40, 1'b0);
    rdc(8'h8a, 8'hff, 1'b1);
    lvl[0] <= 1'b1;
    waiti(8'h00, 40, 1'b1);
    fin(8'h00, 8'h00, 8'h00);
    tmr(8'h01, 8'h05, 8'hff, 8'hff);
    waiti(8'h01, 40, 1'b0);
    crun[1] <= 1'b1;
    waiti(8'h01, 14, 1'b1);
    crun[1] <= 1'b0;
    bitw(8'h8e, 1'b0);
    pulse(8'h01);
    rdc(8'h8d, 8'h00, 1'b1);
    $display("test gate and counter done");
    for (int k = 0; k < 4; k++) begin
      i = 8'(k % 2);
      e = k[1];
      bitw(8'h88 + 8'h02 * i, e);
      lvl[i] <= 1'b0;
      waiti(8'h02 + i, 10, 1'b1);
      pulse(8'h02 + i);
      waiti(8'h02 + i, 0, !e);
      lvl[i] <= 1'b1;
      repeat (8) @(posedge clk);
      waiti(8'h02 + i, 0, 1'b0);
      bitw(8'h88 + 8'h02 * i, 1'b0);
    end
    $display("test external flags done");
    results();
  end
endmodule
